// >>> hdl/urm_register_map.sv
// register bank and offset decoder for a uart with enhanced features
// assumes the serial host port delivers one-cycle read and write strobes
//
// Overview of operation
// - divisor access clear: offset 0 reads oldest receive byte, writes transmit byte.
// - divisor access set and not key: offsets 0 and 1 hold divisor bytes.
// - fractional divisor at offset 2 needs divisor access, no key, enhance bit.
// - divisor access clear: offset 2 reads interrupt source, writes queue control.
// - key in line control: offset 2 is the enhanced function register.
// - key in line control: offsets 4..7 are resume 1, resume 2, halt 1, halt 2.
// - offset 1 in normal bank is the interrupt enable register.
// - offset 3 is always line control, divisor access in top bit.
// - offset 4 in normal bank is modem control.
// - offset 5 reads line state unless key; writes ignored unless key.
// - normal selection: offset 6 reads modem state, offset 7 is scratch byte.
// - alternate selection: offset 6 is flow threshold, resume high, halt low.
// - alternate selection: offset 7 is trigger thresholds, receive high, transmit low.
// - offset 8 reads transmit queue fill in bits 6..0, bit 7 zero.
// - offset 9 reads receive queue fill in bits 6..0, bit 7 zero.
// - offset 0x0A is the gpio direction register.
// - offset 0x0B holds gpio pin state.
// - offset 0x0C enables a gpio interrupt per pin.
// - offset 0x0E is gpio config with soft reset, pin function, latch enable.
// - offset 0x0F is the extra features control register.
// - enhanced bits are writable and effective only while enhance bit set.
// - reserved offset 0x0D reads all zero.
`timescale 1ns/1ps
module urm_register_map
  import urm_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic NRST,
  input wire logic [3:0] REG_ADDR,
  input wire logic REG_WRITE,
  input wire logic REG_READ,
  input wire logic [7:0] REG_WDATA,
  output logic [7:0] REG_RDATA,
  input wire logic [7:0] RX_HOLDING_IN,
  input wire logic [7:0] INTERRUPT_SOURCE_IN,
  input wire logic [7:0] LINE_STATE_IN,
  input wire logic [7:0] MODEM_STATE_IN,
  input wire logic [6:0] TX_QUEUE_FILL_IN,
  input wire logic [6:0] RX_QUEUE_FILL_IN,
  input wire logic [7:0] GPIO_IN,
  output logic RX_POP,
  output logic TX_PUSH,
  output logic [7:0] TX_HOLDING,
  output logic QUEUE_CONTROL_WRITE,
  output logic [7:0] QUEUE_CONTROL,
  output logic LINE_STATE_READ,
  output logic MODEM_STATE_READ,
  output logic UART_SOFT_RESET,
  output logic [15:0] DIVISOR,
  output logic [7:0] DIVISOR_FRACTION,
  output logic [7:0] INTERRUPT_ENABLE,
  output logic [7:0] ENHANCED_FUNCTION,
  output logic [7:0] LINE_CONTROL,
  output logic [7:0] MODEM_CONTROL,
  output logic [7:0] FLOW_RESUME_CHAR_1,
  output logic [7:0] FLOW_RESUME_CHAR_2,
  output logic [7:0] FLOW_HALT_CHAR_1,
  output logic [7:0] FLOW_HALT_CHAR_2,
  output logic [7:0] FLOW_THRESHOLD,
  output logic [7:0] TRIGGER_THRESHOLDS,
  output logic [7:0] SCRATCH_BYTE,
  output logic [7:0] GPIO_DIRECTION,
  output logic [7:0] GPIO_OUT,
  output logic [7:0] GPIO_IRQ_ENABLE,
  output logic [7:0] GPIO_CONFIG,
  output logic [7:0] EXTRA_FEATURES
);

  // -----------------------------------------------------------------------
  // bank selection
  // -----------------------------------------------------------------------
  logic key_bank;
  logic div_bank;
  logic enh_on;
  logic alt_bank;
  logic [7:0] gpio_read;
  logic [7:0] next_rdata;
  logic [7:0] wmask_ier;
  logic [7:0] wmask_mcr;

  assign key_bank = (LINE_CONTROL == ENHANCED_KEY);
  assign div_bank = LINE_CONTROL[LCR_DIV_ACCESS_BIT] && !key_bank;
  assign enh_on = ENHANCED_FUNCTION[EFR_ENHANCE_BIT];
  // alternate pair at 6/7 is chosen by a modem control bit with enhancements on
  assign alt_bank = !key_bank && enh_on && MODEM_CONTROL[MCR_ALT_SELECT_BIT];
  assign wmask_ier = enh_on ? 8'hFF : ~IER_ENH_MASK;
  assign wmask_mcr = enh_on ? 8'hFF : ~MCR_ENH_MASK;

  // output pins read back their driven value, input pins the live level
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_gpio_rd
      assign gpio_read[gi] = GPIO_DIRECTION[gi] ? GPIO_OUT[gi] : GPIO_IN[gi];
    end
  endgenerate

  // -----------------------------------------------------------------------
  // read decode
  // -----------------------------------------------------------------------
  always_comb begin
    next_rdata = 8'h00;
    if (REG_ADDR == OFS_HOLDING) begin
      if (!LINE_CONTROL[LCR_DIV_ACCESS_BIT]) begin
        next_rdata = RX_HOLDING_IN;
      end else if (div_bank) begin
        next_rdata = DIVISOR[7:0];
      end
    end else if (REG_ADDR == OFS_IER_DLM) begin
      if (div_bank) begin
        next_rdata = DIVISOR[15:8];
      end else if (!key_bank) begin
        next_rdata = INTERRUPT_ENABLE;
      end
    end else if (REG_ADDR == OFS_ISR_FCR) begin
      if (key_bank) begin
        next_rdata = ENHANCED_FUNCTION;
      end else if (div_bank) begin
        next_rdata = enh_on ? DIVISOR_FRACTION : 8'h00;
      end else begin
        // enhanced source bits read zero until enhancements are switched on
        next_rdata = enh_on ? INTERRUPT_SOURCE_IN
                            : (INTERRUPT_SOURCE_IN & ~ISR_ENH_MASK);
      end
    end else if (REG_ADDR == OFS_LCR) begin
      next_rdata = LINE_CONTROL;
    end else if (REG_ADDR == OFS_MCR) begin
      next_rdata = key_bank ? FLOW_RESUME_CHAR_1 : MODEM_CONTROL;
    end else if (REG_ADDR == OFS_LSR) begin
      next_rdata = key_bank ? FLOW_RESUME_CHAR_2 : LINE_STATE_IN;
    end else if (REG_ADDR == OFS_MSR) begin
      if (key_bank) begin
        next_rdata = FLOW_HALT_CHAR_1;
      end else if (alt_bank) begin
        next_rdata = FLOW_THRESHOLD;
      end else begin
        next_rdata = MODEM_STATE_IN;
      end
    end else if (REG_ADDR == OFS_SPR) begin
      if (key_bank) begin
        next_rdata = FLOW_HALT_CHAR_2;
      end else if (alt_bank) begin
        next_rdata = TRIGGER_THRESHOLDS;
      end else begin
        next_rdata = SCRATCH_BYTE;
      end
    end else if (REG_ADDR == OFS_TX_FILL) begin
      next_rdata = {1'b0, TX_QUEUE_FILL_IN};
    end else if (REG_ADDR == OFS_RX_FILL) begin
      next_rdata = {1'b0, RX_QUEUE_FILL_IN};
    end else if (REG_ADDR == OFS_GPIO_DIR) begin
      next_rdata = GPIO_DIRECTION;
    end else if (REG_ADDR == OFS_GPIO_STATE) begin
      next_rdata = gpio_read;
    end else if (REG_ADDR == OFS_GPIO_IRQ) begin
      next_rdata = GPIO_IRQ_ENABLE;
    end else if (REG_ADDR == OFS_RESERVED) begin
      next_rdata = 8'h00;
    end else if (REG_ADDR == OFS_GPIO_CFG) begin
      next_rdata = GPIO_CONFIG;
    end else begin
      next_rdata = EXTRA_FEATURES;
    end
  end

  // read data holds until the next read strobe
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      REG_RDATA <= RST_ZERO;
    end else if (REG_READ) begin
      REG_RDATA <= next_rdata;
    end
  end

  // read side effects: pop the receive queue, tell status logic it was read
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      RX_POP <= 1'b0;
      LINE_STATE_READ <= 1'b0;
      MODEM_STATE_READ <= 1'b0;
    end else begin
      RX_POP <= REG_READ && REG_ADDR == OFS_HOLDING
                && !LINE_CONTROL[LCR_DIV_ACCESS_BIT];
      LINE_STATE_READ <= REG_READ && REG_ADDR == OFS_LSR && !key_bank;
      MODEM_STATE_READ <= REG_READ && REG_ADDR == OFS_MSR
                          && !key_bank && !alt_bank;
    end
  end

  // -----------------------------------------------------------------------
  // write pulses to the datapath
  // -----------------------------------------------------------------------
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      TX_PUSH <= 1'b0;
      TX_HOLDING <= RST_ZERO;
      QUEUE_CONTROL_WRITE <= 1'b0;
      QUEUE_CONTROL <= RST_ZERO;
      UART_SOFT_RESET <= 1'b0;
    end else begin
      TX_PUSH <= 1'b0;
      QUEUE_CONTROL_WRITE <= 1'b0;
      UART_SOFT_RESET <= 1'b0;
      if (REG_WRITE && REG_ADDR == OFS_HOLDING && !LINE_CONTROL[LCR_DIV_ACCESS_BIT]) begin
        TX_PUSH <= 1'b1;
        TX_HOLDING <= REG_WDATA;
      end
      if (REG_WRITE && REG_ADDR == OFS_ISR_FCR && !LINE_CONTROL[LCR_DIV_ACCESS_BIT]) begin
        QUEUE_CONTROL_WRITE <= 1'b1;
        QUEUE_CONTROL <= enh_on ? REG_WDATA : (REG_WDATA & ~FCR_ENH_MASK);
      end
      // the soft reset bit is a command and never reads back as one
      if (REG_WRITE && REG_ADDR == OFS_GPIO_CFG) begin
        UART_SOFT_RESET <= REG_WDATA[GPIO_CFG_SOFT_RESET_BIT];
      end
    end
  end

  // -----------------------------------------------------------------------
  // divisor and normal bank
  // -----------------------------------------------------------------------
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      DIVISOR <= {RST_ZERO, RST_DLL};
      DIVISOR_FRACTION <= RST_ZERO;
    end else if (REG_WRITE && div_bank) begin
      if (REG_ADDR == OFS_HOLDING) begin
        DIVISOR[7:0] <= REG_WDATA;
      end else if (REG_ADDR == OFS_IER_DLM) begin
        DIVISOR[15:8] <= REG_WDATA;
      end else if (REG_ADDR == OFS_ISR_FCR && enh_on) begin
        DIVISOR_FRACTION <= REG_WDATA;
      end
    end
  end

  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      LINE_CONTROL <= RST_LCR;
    end else if (REG_WRITE && REG_ADDR == OFS_LCR) begin
      LINE_CONTROL <= REG_WDATA;
    end
  end

  // enhanced bits drop when the enhance bit is cleared so they stop acting
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      INTERRUPT_ENABLE <= RST_ZERO;
      MODEM_CONTROL <= RST_ZERO;
    end else if (REG_WRITE && key_bank && REG_ADDR == OFS_ISR_FCR
                 && !REG_WDATA[EFR_ENHANCE_BIT]) begin
      INTERRUPT_ENABLE <= INTERRUPT_ENABLE & ~IER_ENH_MASK;
      MODEM_CONTROL <= MODEM_CONTROL & ~MCR_ENH_MASK;
    end else if (REG_WRITE && !key_bank) begin
      if (REG_ADDR == OFS_IER_DLM && !div_bank) begin
        INTERRUPT_ENABLE <= (REG_WDATA & wmask_ier)
                            | (INTERRUPT_ENABLE & ~wmask_ier);
      end else if (REG_ADDR == OFS_MCR) begin
        MODEM_CONTROL <= (REG_WDATA & wmask_mcr)
                         | (MODEM_CONTROL & ~wmask_mcr);
      end
    end
  end

  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      FLOW_THRESHOLD <= RST_ZERO;
      TRIGGER_THRESHOLDS <= RST_ZERO;
      SCRATCH_BYTE <= RST_ZERO;
    end else if (REG_WRITE && !key_bank) begin
      if (REG_ADDR == OFS_MSR && alt_bank) begin
        FLOW_THRESHOLD <= REG_WDATA;
      end else if (REG_ADDR == OFS_SPR && alt_bank) begin
        TRIGGER_THRESHOLDS <= REG_WDATA;
      end else if (REG_ADDR == OFS_SPR) begin
        SCRATCH_BYTE <= REG_WDATA;
      end
    end
  end

  // -----------------------------------------------------------------------
  // enhanced bank
  // -----------------------------------------------------------------------
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      ENHANCED_FUNCTION <= RST_ZERO;
      FLOW_RESUME_CHAR_1 <= RST_ZERO;
      FLOW_RESUME_CHAR_2 <= RST_ZERO;
      FLOW_HALT_CHAR_1 <= RST_ZERO;
      FLOW_HALT_CHAR_2 <= RST_ZERO;
    end else if (REG_WRITE && key_bank) begin
      if (REG_ADDR == OFS_ISR_FCR) begin
        ENHANCED_FUNCTION <= REG_WDATA;
      end else if (REG_ADDR == OFS_MCR) begin
        FLOW_RESUME_CHAR_1 <= REG_WDATA;
      end else if (REG_ADDR == OFS_LSR) begin
        FLOW_RESUME_CHAR_2 <= REG_WDATA;
      end else if (REG_ADDR == OFS_MSR) begin
        FLOW_HALT_CHAR_1 <= REG_WDATA;
      end else if (REG_ADDR == OFS_SPR) begin
        FLOW_HALT_CHAR_2 <= REG_WDATA;
      end
    end
  end

  // -----------------------------------------------------------------------
  // gpio and extra features, reachable in every bank
  // -----------------------------------------------------------------------
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      GPIO_DIRECTION <= RST_ZERO;
      GPIO_OUT <= RST_ZERO;
      GPIO_IRQ_ENABLE <= RST_ZERO;
      GPIO_CONFIG <= RST_ZERO;
      EXTRA_FEATURES <= RST_ZERO;
    end else if (REG_WRITE) begin
      if (REG_ADDR == OFS_GPIO_DIR) begin
        GPIO_DIRECTION <= REG_WDATA;
      end else if (REG_ADDR == OFS_GPIO_STATE) begin
        GPIO_OUT <= REG_WDATA;
      end else if (REG_ADDR == OFS_GPIO_IRQ) begin
        GPIO_IRQ_ENABLE <= REG_WDATA;
      end else if (REG_ADDR == OFS_GPIO_CFG) begin
        GPIO_CONFIG <= REG_WDATA & GPIO_CFG_MASK;
      end else if (REG_ADDR == OFS_EXTRA) begin
        EXTRA_FEATURES <= REG_WDATA & EXTRA_MASK;
      end
    end
  end

endmodule : urm_register_map

// >>> hdl/urm_pkg.sv
// register map constants for the uart register decoder
// assumes a 4-bit register offset and 8-bit register data
package urm_pkg;

  // ---------------------------------------------------------------------
  // offsets
  // ---------------------------------------------------------------------
  localparam logic [3:0] OFS_HOLDING = 4'h0;
  localparam logic [3:0] OFS_IER_DLM = 4'h1;
  localparam logic [3:0] OFS_ISR_FCR = 4'h2;
  localparam logic [3:0] OFS_LCR = 4'h3;
  localparam logic [3:0] OFS_MCR = 4'h4;
  localparam logic [3:0] OFS_LSR = 4'h5;
  localparam logic [3:0] OFS_MSR = 4'h6;
  localparam logic [3:0] OFS_SPR = 4'h7;
  localparam logic [3:0] OFS_TX_FILL = 4'h8;
  localparam logic [3:0] OFS_RX_FILL = 4'h9;
  localparam logic [3:0] OFS_GPIO_DIR = 4'hA;
  localparam logic [3:0] OFS_GPIO_STATE = 4'hB;
  localparam logic [3:0] OFS_GPIO_IRQ = 4'hC;
  localparam logic [3:0] OFS_RESERVED = 4'hD;
  localparam logic [3:0] OFS_GPIO_CFG = 4'hE;
  localparam logic [3:0] OFS_EXTRA = 4'hF;

  // ---------------------------------------------------------------------
  // fields and keys
  // ---------------------------------------------------------------------
  localparam logic [7:0] ENHANCED_KEY = 8'hBF;
  localparam int LCR_DIV_ACCESS_BIT = 7;
  localparam int EFR_ENHANCE_BIT = 4;
  localparam int MCR_ALT_SELECT_BIT = 2;
  localparam int GPIO_CFG_SOFT_RESET_BIT = 3;
  // bits only writable (readable, for ISR) while the enhance bit is set
  localparam logic [7:0] IER_ENH_MASK = 8'hF0;
  localparam logic [7:0] FCR_ENH_MASK = 8'h30;
  localparam logic [7:0] ISR_ENH_MASK = 8'h30;
  localparam logic [7:0] MCR_ENH_MASK = 8'hE0;
  // bits that exist; the rest read zero
  localparam logic [7:0] GPIO_CFG_MASK = 8'h03;
  localparam logic [7:0] EXTRA_MASK = 8'hB7;
  localparam logic [7:0] FILL_MASK = 8'h7F;

  // ---------------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------------
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_LCR = 8'h1D;
  localparam logic [7:0] RST_DLL = 8'h01;

endpackage : urm_pkg

// >>> tb/urm_register_map_props.sv
// concurrent checks on the register map decoder ports
// assumes one clock domain and one-cycle read and write strobes
`timescale 1ns/1ps
module urm_register_map_props
  import urm_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic NRST,
  input wire logic [3:0] REG_ADDR,
  input wire logic REG_WRITE,
  input wire logic REG_READ,
  input wire logic [7:0] REG_WDATA,
  input wire logic [7:0] REG_RDATA,
  input wire logic [7:0] LINE_STATE_IN,
  input wire logic [6:0] TX_QUEUE_FILL_IN,
  input wire logic [6:0] RX_QUEUE_FILL_IN,
  input wire logic RX_POP,
  input wire logic TX_PUSH,
  input wire logic [7:0] TX_HOLDING,
  input wire logic LINE_STATE_READ,
  input wire logic MODEM_STATE_READ,
  input wire logic QUEUE_CONTROL_WRITE,
  input wire logic UART_SOFT_RESET,
  input wire logic [15:0] DIVISOR,
  input wire logic [7:0] ENHANCED_FUNCTION,
  input wire logic [7:0] LINE_CONTROL,
  input wire logic [7:0] MODEM_CONTROL
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!NRST);

  property p_rx_pop; REG_READ && REG_ADDR == 4'h0 && !LINE_CONTROL[7] |=> RX_POP; endproperty
  a_rx_pop: assert property (p_rx_pop) else $error("receive pop missing");
  property p_tx_push;
    REG_WRITE && REG_ADDR == 4'h0 && !LINE_CONTROL[7] |=> TX_PUSH && TX_HOLDING == $past(REG_WDATA);
  endproperty
  a_tx_push: assert property (p_tx_push) else $error("transmit push wrong");
  property p_push_cause; TX_PUSH |-> $past(REG_WRITE) && $past(REG_ADDR) == 4'h0; endproperty
  a_push_cause: assert property (p_push_cause) else $error("stray transmit push");
  property p_div_low;
    REG_WRITE && REG_ADDR == 4'h0 && LINE_CONTROL[7] && LINE_CONTROL != ENHANCED_KEY
      |=> DIVISOR[7:0] == $past(REG_WDATA);
  endproperty
  a_div_low: assert property (p_div_low) else $error("divisor low not written");
  property p_efr; REG_WRITE && REG_ADDR == 4'h2 && LINE_CONTROL == ENHANCED_KEY
    |=> ENHANCED_FUNCTION == $past(REG_WDATA); endproperty
  a_efr: assert property (p_efr) else $error("enhanced function not written");
  property p_lcr; REG_WRITE && REG_ADDR == 4'h3 |=> LINE_CONTROL == $past(REG_WDATA); endproperty
  a_lcr: assert property (p_lcr) else $error("line control not written");
  property p_lsr; REG_READ && REG_ADDR == 4'h5 && LINE_CONTROL != ENHANCED_KEY
    |=> LINE_STATE_READ && REG_RDATA == $past(LINE_STATE_IN); endproperty
  a_lsr: assert property (p_lsr) else $error("line state read wrong");
  property p_tx_fill; REG_READ && REG_ADDR == 4'h8 |=> REG_RDATA == {1'b0, $past(TX_QUEUE_FILL_IN)};
  endproperty
  a_tx_fill: assert property (p_tx_fill) else $error("transmit fill wrong");
  property p_rx_fill; REG_READ && REG_ADDR == 4'h9 |=> REG_RDATA == {1'b0, $past(RX_QUEUE_FILL_IN)};
  endproperty
  a_rx_fill: assert property (p_rx_fill) else $error("receive fill wrong");
  property p_rsvd; REG_READ && REG_ADDR == 4'hD |=> REG_RDATA == 8'h00; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved slot not zero");
  property p_soft_rst; REG_WRITE && REG_ADDR == 4'hE && REG_WDATA[3] |=> UART_SOFT_RESET; endproperty
  a_soft_rst: assert property (p_soft_rst) else $error("soft reset pulse missing");
  property p_fcr_write; REG_WRITE && REG_ADDR == 4'h2 && !LINE_CONTROL[7] |=> QUEUE_CONTROL_WRITE;
  endproperty
  a_fcr_write: assert property (p_fcr_write) else $error("queue control pulse missing");
  property p_msr_read; REG_READ && REG_ADDR == 4'h6 && LINE_CONTROL != ENHANCED_KEY
    && !(ENHANCED_FUNCTION[4] && MODEM_CONTROL[2]) |=> MODEM_STATE_READ; endproperty
  a_msr_read: assert property (p_msr_read) else $error("modem state read pulse missing");
endmodule : urm_register_map_props

bind urm_register_map urm_register_map_props i_props (.REF_CLK, .NRST, .REG_ADDR, .REG_WRITE,
  .REG_READ, .REG_WDATA, .REG_RDATA, .LINE_STATE_IN, .TX_QUEUE_FILL_IN, .RX_QUEUE_FILL_IN,
  .RX_POP, .TX_PUSH, .TX_HOLDING, .LINE_STATE_READ, .UART_SOFT_RESET, .DIVISOR,
  .ENHANCED_FUNCTION, .LINE_CONTROL, .MODEM_STATE_READ, .QUEUE_CONTROL_WRITE,
  .MODEM_CONTROL);

// >>> tb/urm_core_model.sv
// behavioural queue side of the uart: receive byte and fill counts
// assumes pop and push pulses last one clock
`timescale 1ns/1ps
module urm_core_model (
  input wire logic clk,
  input wire logic nrst,
  input wire logic rx_pop,
  input wire logic tx_push,
  output logic [7:0] rx_byte,
  output logic [6:0] rx_fill,
  output logic [6:0] tx_fill
);
  // the next byte differs from the last so a missed pop shows up
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rx_byte <= 8'h40;
      rx_fill <= 7'h05;
      tx_fill <= 7'h00;
    end else begin
      if (rx_pop) begin
        rx_byte <= rx_byte + 8'h01;
        rx_fill <= rx_fill - 7'h01;
      end
      if (tx_push) begin
        tx_fill <= tx_fill + 7'h01;
      end
    end
  end
endmodule : urm_core_model

// >>> tb/tb_urm_register_map.sv
// self-checking bench for the uart register map decoder
// assumes the design answers reads and writes one edge after the strobe
`timescale 1ns/1ps
module tb_urm_register_map;
  import urm_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [3:0] addr = 4'h0;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata, rx_byte, tx_hold, qctl, resume1, halt2, thresh, trig, gpio_out;
  logic [6:0] tx_fill, rx_fill;
  logic rx_pop, tx_push;
  logic [15:0] divisor;
  int n_mismatch = 0;
  int checked = 0;
  logic [3:0] ra [5] = '{4'h4, 4'h7, 4'hA, 4'hC, 4'hF};
  logic [7:0] rw [5] = '{8'h13, 8'h5A, 8'h0F, 8'h81, 8'hFF};
  logic [7:0] re [5] = '{8'h13, 8'h5A, 8'h0F, 8'h81, 8'hB7};

  always #25 clk = ~clk;

  urm_core_model i_core (.clk(clk), .nrst(nrst), .rx_pop(rx_pop), .tx_push(tx_push),
    .rx_byte(rx_byte), .rx_fill(rx_fill), .tx_fill(tx_fill));

  urm_register_map i_dut (.REF_CLK(clk), .NRST(nrst), .REG_ADDR(addr), .REG_WRITE(wr_en),
    .REG_READ(rd_en), .REG_WDATA(wdata), .REG_RDATA(rdata), .RX_HOLDING_IN(rx_byte),
    .INTERRUPT_SOURCE_IN(8'hF1), .LINE_STATE_IN(8'h60), .MODEM_STATE_IN(8'hB0),
    .TX_QUEUE_FILL_IN(tx_fill), .RX_QUEUE_FILL_IN(rx_fill), .GPIO_IN(8'h5C),
    .RX_POP(rx_pop), .TX_PUSH(tx_push), .TX_HOLDING(tx_hold), .QUEUE_CONTROL_WRITE(),
    .QUEUE_CONTROL(qctl), .LINE_STATE_READ(), .MODEM_STATE_READ(), .UART_SOFT_RESET(),
    .DIVISOR(divisor), .DIVISOR_FRACTION(), .INTERRUPT_ENABLE(), .ENHANCED_FUNCTION(),
    .LINE_CONTROL(), .MODEM_CONTROL(), .FLOW_RESUME_CHAR_1(resume1), .FLOW_RESUME_CHAR_2(),
    .FLOW_HALT_CHAR_1(), .FLOW_HALT_CHAR_2(halt2), .FLOW_THRESHOLD(thresh),
    .TRIGGER_THRESHOLDS(trig), .SCRATCH_BYTE(), .GPIO_DIRECTION(), .GPIO_OUT(gpio_out),
    .GPIO_IRQ_ENABLE(), .GPIO_CONFIG(), .EXTRA_FEATURES());

  task automatic summarize();
    $display("mismatches=%0d checks=%0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : summarize

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // strobes rise 1 ns after an edge and fall 1 ns after the sampling edge
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    addr = a;
    wdata = d;
    wr_en = 1'b1;
    @(posedge clk);
    #1;
    wr_en = 1'b0;
  endtask : wr

  task automatic rdchk(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk);
    #1;
    addr = a;
    rd_en = 1'b1;
    @(posedge clk);
    #1;
    rd_en = 1'b0;
    chk({8'h00, rdata}, {8'h00, exp});
  endtask : rdchk

  initial begin
    #(4000 * 50);
    n_mismatch++;
    summarize();
  end

  initial begin
    repeat (6) @(posedge clk);
    #1;
    nrst = 1'b1;
    rdchk(OFS_LCR, RST_LCR);
    rdchk(OFS_HOLDING, 8'h40);
    wr(OFS_HOLDING, 8'hA5);
    chk({8'h00, tx_hold}, 16'h00A5);
    wr(OFS_IER_DLM, 8'hFF);
    rdchk(OFS_IER_DLM, 8'h0F);
    wr(OFS_ISR_FCR, 8'h37);
    chk({8'h00, qctl}, 16'h0007);
    rdchk(OFS_ISR_FCR, 8'hC1);
    for (int i = 0; i < 5; i++) begin
      wr(ra[i], rw[i]);
      rdchk(ra[i], re[i]);
    end
    wr(OFS_LSR, 8'h00);
    rdchk(OFS_LSR, 8'h60);
    rdchk(OFS_MSR, 8'hB0);
    rdchk(OFS_TX_FILL, 8'h01);
    rdchk(OFS_RX_FILL, 8'h04);
    wr(OFS_RESERVED, 8'h55);
    rdchk(OFS_RESERVED, 8'h00);
    wr(OFS_GPIO_STATE, 8'h3A);
    chk({8'h00, gpio_out}, 16'h003A);
    rdchk(OFS_GPIO_STATE, 8'h5A);
    wr(OFS_LCR, 8'h83);
    wr(OFS_HOLDING, 8'h12);
    wr(OFS_IER_DLM, 8'h34);
    chk(divisor, 16'h3412);
    rdchk(OFS_HOLDING, 8'h12);
    wr(OFS_ISR_FCR, 8'h09);
    rdchk(OFS_ISR_FCR, 8'h00);
    wr(OFS_LCR, ENHANCED_KEY);
    wr(OFS_ISR_FCR, 8'h10);
    rdchk(OFS_ISR_FCR, 8'h10);
    for (int i = 0; i < 4; i++) begin
      wr(OFS_MCR + 4'(i), 8'h11 * 8'(i + 1));
      rdchk(OFS_MCR + 4'(i), 8'h11 * 8'(i + 1));
    end
    chk({resume1, halt2}, 16'h1144);
    wr(OFS_LCR, 8'h83);
    wr(OFS_ISR_FCR, 8'h09);
    rdchk(OFS_ISR_FCR, 8'h09);
    wr(OFS_LCR, 8'h03);
    rdchk(OFS_ISR_FCR, 8'hF1);
    wr(OFS_IER_DLM, 8'hF5);
    rdchk(OFS_IER_DLM, 8'hF5);
    wr(OFS_MCR, 8'h04);
    wr(OFS_MSR, 8'h4A);
    rdchk(OFS_MSR, 8'h4A);
    chk({8'h00, thresh}, 16'h004A);
    wr(OFS_SPR, 8'h3C);
    rdchk(OFS_SPR, 8'h3C);
    chk({8'h00, trig}, 16'h003C);
    wr(OFS_GPIO_CFG, 8'h0B);
    rdchk(OFS_GPIO_CFG, 8'h03);
    wr(OFS_LCR, ENHANCED_KEY);
    wr(OFS_ISR_FCR, 8'h00);
    wr(OFS_LCR, 8'h03);
    rdchk(OFS_IER_DLM, 8'h05);
    rdchk(OFS_MSR, 8'hB0);
    rdchk(OFS_ISR_FCR, 8'hC1);
    summarize();
  end
endmodule : tb_urm_register_map
